// ---- cmp_pkg.sv ----
package cmp_pkg;

    // ----------------------------------------------------------------
    // Sizes and timing
    // ----------------------------------------------------------------
    localparam int          UNITS          = 8;
    localparam int          CLK_PERIOD_NS  = 40;
    localparam int          FILTER_HOLD_NS = 20;
    localparam int          HOLD_RAW       = (FILTER_HOLD_NS + CLK_PERIOD_NS
                                              - 1) / CLK_PERIOD_NS;
    localparam int          HOLD_INT       = (HOLD_RAW < 1) ? 1 : HOLD_RAW;
    localparam logic [3:0]  HOLD_CYCLES    = HOLD_INT[3:0];
    localparam logic [3:0]  HOLD_ZERO      = 4'h0;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] UNIT_SPAN_MASK = 12'hf80;
    localparam logic [1:0]  REG_CTRL_A     = 2'h0;
    localparam logic [1:0]  REG_CTRL_B     = 2'h1;
    localparam logic [1:0]  REG_PLUS_SEL   = 2'h2;
    localparam logic [1:0]  REG_MINUS_SEL  = 2'h3;
    localparam logic [11:0] ADDR_RESULT    = 12'h080;
    localparam logic [11:0] ADDR_IRQ_FLAG  = 12'h084;
    localparam logic [11:0] ADDR_IRQ_MASK  = 12'h088;
    localparam logic [11:0] ADDR_IRQ_CTRL  = 12'h08c;
    localparam logic [11:0] ADDR_PIN_ROUTE = 12'h090;
    localparam logic [11:0] ADDR_PIN_DIR   = 12'h094;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_ENABLE   = 7;
    localparam int BIT_RESULT   = 6;
    localparam int BIT_RSVD_HI  = 5;
    localparam int BIT_INVERT   = 4;
    localparam int BIT_FILTER   = 3;
    localparam int BIT_RSVD_LO  = 2;
    localparam int BIT_SEPARATE = 1;
    localparam int BIT_LATCH    = 0;
    localparam int BIT_RISE_EN  = 1;
    localparam int BIT_FALL_EN  = 0;
    localparam int BIT_PERIPH_G = 0;
    localparam int BIT_GLOBAL_G = 1;

    localparam logic [7:0]  CTRL_A_WMASK   = 8'h9b;
    localparam logic [7:0]  CTRL_A_RESET   = 8'h00;
    localparam logic [3:0]  SEL_RESET      = 4'h0;
    localparam logic [3:0]  MINUS_SEL_PIN  = 4'h0;
    localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;

    typedef struct packed {
        logic [7:0]      sync1;
        logic [7:0]      sync2;
        logic [7:0]      filt;
        logic [7:0][3:0] hold;
        logic [7:0]      final_v;
        logic [7:0]      latched;
        logic [7:0]      gate_out;
        logic [7:0]      pin_out;
        logic [7:0]      pin_oe;
        logic [7:0]      flag;
        logic [7:0][7:0] ctrl_a;
        logic [7:0][1:0] ctrl_b;
        logic [7:0][3:0] plus_f;
        logic [7:0][3:0] minus_f;
        logic [7:0]      mask;
        logic [7:0]      route;
        logic [7:0]      dir;
        logic [1:0]      gates;
        logic [7:0]      sep_out;
        logic [7:0]      conn_out;
        logic [7:0][3:0] plus_out;
        logic [7:0][3:0] minus_out;
        logic [7:0]      amp_route;
        logic            tclk_prev;
        logic            irq;
        logic            pready;
        logic            pslverr;
        logic [31:0]     prdata;
    } state_t;

endpackage

// ---- comparator_output_logic.sv ----
// Overview of operation
// - Raw result high when plus exceeds minus
// - Enable bit runs comparator, clear disables
// - Result readable per unit and shared
// - Pin driven only when routed, output, enabled
// - Internal result registered every cycle
// - Invert select complements the filtered result
// - Separation bit drives hysteresis control output
// - Each result offered as timer gate source
// - Latch mode captures on timer clock fall
// - Prescaled timer clock used when prescaler on
// - Timer counts rising, latch updates falling
// - Rise and fall detectors set irq flag
// - Software clears flag; new edge wins
// - Enable or invert toggles make edges too
// - Four-bit plus source select field
// - Disabled unit disconnects all its inputs
// - Four-bit minus source select field
// - Enabled amplifier output feeds minus input at minus select 0
// - Filter blocks reversal for nominal 20 ns
// - Filter active when control bit 3 set
// - Edges watch final result after inversion
`timescale 1ns/1ps

module comparator_output_logic (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [7:0]  raw_compare,
    input  wire logic [7:0]  opamp_enable,
    input  wire logic        timer_src_clk,
    input  wire logic        timer_presc_clk,
    input  wire logic        timer_presc_en,
    output logic      [7:0]  gate_source,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe,
    output logic      [7:0]  separation_on,
    output logic      [7:0]  input_connect,
    output logic      [31:0] plus_source,
    output logic      [31:0] minus_source,
    output logic      [7:0]  minus_from_opamp,
    output logic             irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    cmp_pkg::state_t s_q;
    cmp_pkg::state_t s_d;

    logic        wr_hit;
    logic        rd_start;
    logic        tclk_cur;
    logic        tclk_fall;
    logic        unit_space;
    logic [2:0]  unit_idx;
    logic [1:0]  reg_idx;
    logic        en;
    logic        inv;
    logic        gated;
    logic        rise;
    logic        fall;
    logic        set_ev;
    logic [31:0] rd_val;
    logic        rd_err;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_d        = s_q;
        en         = 1'b0;
        inv        = 1'b0;
        gated      = 1'b0;
        rise       = 1'b0;
        fall       = 1'b0;
        set_ev     = 1'b0;
        rd_val     = cmp_pkg::RDATA_ZERO;
        rd_err     = 1'b0;

        unit_space = (paddr & cmp_pkg::UNIT_SPAN_MASK) == 12'h000;
        unit_idx   = paddr[6:4];
        reg_idx    = paddr[3:2];

        // Write lands at the edge where pready is seen high
        wr_hit   = psel & penable & pwrite & s_q.pready;
        rd_start = psel & penable & ~s_q.pready;

        // Asynchronous comparator result into the clock domain
        s_d.sync1 = raw_compare;
        s_d.sync2 = s_q.sync1;

        // Prescaler output replaces raw timer clock when in use
        tclk_cur      = timer_presc_en ? timer_presc_clk
                                       : timer_src_clk;
        s_d.tclk_prev = tclk_cur;
        tclk_fall     = s_q.tclk_prev & ~tclk_cur;

        // ------------------------------------------------------------
        // Register read mux
        // ------------------------------------------------------------
        if (unit_space) begin
            unique case (reg_idx)
                cmp_pkg::REG_CTRL_A: begin
                    rd_val[7:0] = s_q.ctrl_a[unit_idx]
                                & cmp_pkg::CTRL_A_WMASK;
                    rd_val[cmp_pkg::BIT_RESULT] =
                        s_q.final_v[unit_idx];
                    rd_val[cmp_pkg::BIT_RSVD_HI] = 1'b1;
                    rd_val[cmp_pkg::BIT_RSVD_LO] = 1'b1;
                end
                cmp_pkg::REG_CTRL_B: begin
                    rd_val[1:0] = s_q.ctrl_b[unit_idx];
                end
                cmp_pkg::REG_PLUS_SEL: begin
                    rd_val[3:0] = s_q.plus_f[unit_idx];
                end
                cmp_pkg::REG_MINUS_SEL: begin
                    rd_val[3:0] = s_q.minus_f[unit_idx];
                end
            endcase
        end else begin
            unique case (paddr)
                cmp_pkg::ADDR_RESULT:    rd_val[7:0] = s_q.final_v;
                cmp_pkg::ADDR_IRQ_FLAG:  rd_val[7:0] = s_q.flag;
                cmp_pkg::ADDR_IRQ_MASK:  rd_val[7:0] = s_q.mask;
                cmp_pkg::ADDR_IRQ_CTRL:  rd_val[1:0] = s_q.gates;
                cmp_pkg::ADDR_PIN_ROUTE: rd_val[7:0] = s_q.route;
                cmp_pkg::ADDR_PIN_DIR:   rd_val[7:0] = s_q.dir;
                default:                 rd_err      = 1'b1;
            endcase
        end

        // ------------------------------------------------------------
        // APB answer: one wait state, data and error with pready
        // ------------------------------------------------------------
        s_d.pready  = rd_start;
        s_d.pslverr = rd_start & rd_err;
        s_d.prdata  = (rd_start & ~pwrite & ~rd_err) ? rd_val
                                                     : cmp_pkg::RDATA_ZERO;

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        if (wr_hit & unit_space) begin
            unique case (reg_idx)
                cmp_pkg::REG_CTRL_A:
                    s_d.ctrl_a[unit_idx] = pwdata[7:0]
                                         & cmp_pkg::CTRL_A_WMASK;
                cmp_pkg::REG_CTRL_B:
                    s_d.ctrl_b[unit_idx] = pwdata[1:0];
                cmp_pkg::REG_PLUS_SEL:
                    s_d.plus_f[unit_idx] = pwdata[3:0];
                cmp_pkg::REG_MINUS_SEL:
                    s_d.minus_f[unit_idx] = pwdata[3:0];
            endcase
        end else if (wr_hit) begin
            unique case (paddr)
                cmp_pkg::ADDR_IRQ_FLAG:
                    s_d.flag = s_q.flag & ~pwdata[7:0];
                cmp_pkg::ADDR_IRQ_MASK:  s_d.mask  = pwdata[7:0];
                cmp_pkg::ADDR_IRQ_CTRL:  s_d.gates = pwdata[1:0];
                cmp_pkg::ADDR_PIN_ROUTE: s_d.route = pwdata[7:0];
                cmp_pkg::ADDR_PIN_DIR:   s_d.dir   = pwdata[7:0];
                default: ;
            endcase
        end

        // ------------------------------------------------------------
        // Per-unit result path
        // ------------------------------------------------------------
        for (int i = 0; i < cmp_pkg::UNITS; i++) begin
            en  = s_q.ctrl_a[i][cmp_pkg::BIT_ENABLE];
            inv = s_q.ctrl_a[i][cmp_pkg::BIT_INVERT];

            // Disabled unit reads low, so enable toggles give edges
            gated = en & s_q.sync2[i];

            // Hold-off only blocks changes, never delays the first
            if (s_q.ctrl_a[i][cmp_pkg::BIT_FILTER] &&
                s_q.hold[i] != cmp_pkg::HOLD_ZERO) begin
                s_d.hold[i] = s_q.hold[i] - 4'h1;
            end else begin
                s_d.filt[i] = gated;
                if (s_q.ctrl_a[i][cmp_pkg::BIT_FILTER] &&
                    gated != s_q.filt[i]) begin
                    s_d.hold[i] = cmp_pkg::HOLD_CYCLES;
                end else begin
                    s_d.hold[i] = cmp_pkg::HOLD_ZERO;
                end
            end

            s_d.final_v[i] = s_d.filt[i] ^ inv;

            rise   = s_d.final_v[i] & ~s_q.final_v[i];
            fall   = ~s_d.final_v[i] & s_q.final_v[i];
            set_ev = (rise & s_q.ctrl_b[i][cmp_pkg::BIT_RISE_EN])
                   | (fall & s_q.ctrl_b[i][cmp_pkg::BIT_FALL_EN]);
            // Set applied after the clear so a same-cycle edge wins
            s_d.flag[i] = s_d.flag[i] | set_ev;

            // Only the falling timer edge moves the latch, so the
            // timer's rising-edge count never sees it mid-change
            if (tclk_fall) begin
                s_d.latched[i] = s_q.final_v[i];
            end

            s_d.gate_out[i] = s_q.ctrl_a[i][cmp_pkg::BIT_LATCH]
                            ? s_d.latched[i]
                            : s_d.final_v[i];
            s_d.pin_out[i]  = s_d.gate_out[i];
            s_d.pin_oe[i]   = s_q.route[i] & ~s_q.dir[i] & en;

            s_d.sep_out[i]  = s_q.ctrl_a[i][cmp_pkg::BIT_SEPARATE];

            // Select fields kept but every input opened when off
            s_d.conn_out[i]  = en;
            s_d.plus_out[i]  = en ? s_q.plus_f[i]
                                  : cmp_pkg::SEL_RESET;
            s_d.minus_out[i] = en ? s_q.minus_f[i]
                                  : cmp_pkg::SEL_RESET;
            s_d.amp_route[i] = en & opamp_enable[i]
                             & (s_q.minus_f[i] == cmp_pkg::MINUS_SEL_PIN);
        end

        s_d.irq = (|(s_d.flag & s_d.mask))
                & s_q.gates[cmp_pkg::BIT_PERIPH_G]
                & s_q.gates[cmp_pkg::BIT_GLOBAL_G];
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata           = s_q.prdata;
    assign pready           = s_q.pready;
    assign pslverr          = s_q.pslverr;
    assign gate_source      = s_q.gate_out;
    assign pin_out          = s_q.pin_out;
    assign pin_oe           = s_q.pin_oe;
    assign separation_on    = s_q.sep_out;
    assign input_connect    = s_q.conn_out;
    assign plus_source      = s_q.plus_out;
    assign minus_source     = s_q.minus_out;
    assign minus_from_opamp = s_q.amp_route;
    assign irq              = s_q.irq;

endmodule // comparator_output_logic

// ---- analog_timer_model.sv ----
`timescale 1ns/1ps
module analog_timer_model (
    input  wire logic       clk,
    input  wire logic [7:0] level,
    input  wire logic [1:0] run,
    output logic      [7:0] raw_compare,
    output logic            timer_src_clk,
    output logic            timer_presc_clk
);
    // ------------------------------------------------------------
    // Analog levels and gate timer clocks
    // ------------------------------------------------------------
    logic [7:0] raw_q = 8'h00;
    logic [1:0] src_q = 2'h0;
    logic [2:0] pre_q = 3'h0;

    // Clocks freeze while run is low, like a stopped timer
    always @(posedge clk) begin
        raw_q <= level;
        if (run[0]) begin
            src_q <= src_q + 2'h1;
        end
        if (run[1]) begin
            pre_q <= pre_q + 3'h1;
        end
    end
    assign raw_compare     = raw_q;
    assign timer_src_clk   = src_q[1];
    assign timer_presc_clk = pre_q[2];
endmodule // analog_timer_model

// ---- cmp_checker_sva.sv ----
`timescale 1ns/1ps
module cmp_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [7:0]  opamp_enable,
    input wire logic [7:0]  gate_source,
    input wire logic [7:0]  pin_out,
    input wire logic [7:0]  pin_oe,
    input wire logic [7:0]  separation_on,
    input wire logic [7:0]  input_connect,
    input wire logic [31:0] plus_source,
    input wire logic [7:0]  minus_from_opamp
);
    // ------------------------------------------------------------
    // Port relations
    // ------------------------------------------------------------
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);

    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("access phase length wrong");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    pin_gate_a: assert property ((pin_oe & ~input_connect) == 8'h00)
        else $error("pin driven by disabled unit");
    pin_copy_a: assert property (pin_out == gate_source)
        else $error("pin and gate results differ");
    off_source_a: assert property (input_connect == 8'h00 |->
        plus_source == 32'h0) else $error("disabled unit still sourced");
    opamp_feed_a: assert property ((minus_from_opamp
        & ~($past(opamp_enable) & input_connect)) == 8'h00)
        else $error("amplifier feed without cause");
    sep_write_a: assert property ($changed(separation_on) |->
        (pready && pwrite) || $past(pready && pwrite)
        || $past(pready && pwrite, 2))
        else $error("separation changed without a write");

    cover property (pslverr);
    cover property ($rose(pin_oe[0]));
    cover property ($rose(minus_from_opamp[0]));
endmodule // cmp_checker

bind comparator_output_logic cmp_checker chk_u (
    .clk, .rst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .opamp_enable, .gate_source, .pin_out, .pin_oe, .separation_on,
    .input_connect, .plus_source, .minus_from_opamp
);

// ---- tb_comparator_output_logic.sv ----
`timescale 1ns/1ps
module tb_comparator_output_logic;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pre_en = 1'b0, pready, pslverr, irq;
    logic        tsrc, tpre;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, plus_s, minus_s;
    logic [7:0]  lvl = 8'h00, opa = 8'h00, v, raw, gate, pout, poe;
    logic [7:0]  sep, conn, mfo;
    logic [1:0]  run = 2'h0;
    logic [32:0] exp_q[$];
    int          num_errors = 0;
    int          n_compared = 0;

    comparator_output_logic dut_u (
        .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .raw_compare(raw), .opamp_enable(opa),
        .timer_src_clk(tsrc), .timer_presc_clk(tpre),
        .timer_presc_en(pre_en), .gate_source(gate), .pin_out(pout),
        .pin_oe(poe), .separation_on(sep), .input_connect(conn),
        .plus_source(plus_s), .minus_source(minus_s),
        .minus_from_opamp(mfo), .irq
    );
    analog_timer_model far_u (
        .clk, .level(lvl), .run, .raw_compare(raw),
        .timer_src_clk(tsrc), .timer_presc_clk(tpre)
    );

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Expected answer is queued at setup; pready is judged mid-cycle
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        exp_q.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        do @(negedge clk); while (pready !== 1'b1);
        @(posedge clk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    always @(negedge clk) begin
        if (pready === 1'b1) begin
            chk({pslverr, prdata}, exp_q.pop_front());
        end
    end

    initial forever #20 clk = ~clk;

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        results();
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        void'($urandom(76604));
        idle(8);
        rst <= 1'b0;
        rd(12'h000, 32'h24);
        apb(1'b0, 12'hffc, 32'h0, {1'b1, 32'h0});
        for (int i = 0; i < 4; i++) begin
            v = 8'($urandom);
            lvl <= v;
            for (int u = 0; u < 8; u++) begin
                wr(12'(u * 16), {24'h0, 3'h4, i[0], 4'h0});
            end
            idle(4);
            rd(12'h080, {24'h0, v ^ {8{i[0]}}});
            rd(12'h000, {24'h0, 1'b1, v[0] ^ i[0], 1'b1, i[0], 4'h4});
        end
        lvl <= 8'h00;
        wr(12'h000, 32'h80);
        wr(12'h004, 32'h2);
        wr(12'h088, 32'h1);
        wr(12'h08c, 32'h3);
        wr(12'h084, 32'hff);
        lvl <= 8'h01;
        idle(6);
        rd(12'h084, 32'h1);
        chk(33'(irq), 33'h1);
        wr(12'h084, 32'h1);
        rd(12'h084, 32'h0);
        chk(33'(irq), 33'h0);
        wr(12'h004, 32'h1);
        lvl <= 8'h00;
        idle(6);
        rd(12'h084, 32'h1);
        wr(12'h000, 32'h81);
        lvl <= 8'h01;
        idle(8);
        chk(33'(gate[0]), 33'h0);
        run <= 2'h1;
        idle(12);
        chk(33'(gate[0]), 33'h1);
        chk(33'(pout[0]), 33'h1);
        pre_en <= 1'b1;
        lvl <= 8'h00;
        idle(12);
        chk(33'(gate[0]), 33'h1);
        run <= 2'h3;
        idle(20);
        chk(33'(gate[0]), 33'h0);
        chk(33'(pout[0]), 33'h0);
        run <= 2'h0;
        wr(12'h000, 32'h82);
        wr(12'h008, 32'h5);
        wr(12'h01c, 32'h3);
        wr(12'h090, 32'h1);
        opa <= 8'h01;
        idle(4);
        chk(33'(plus_s), 33'h5);
        chk(33'(minus_s), 33'h30);
        chk(33'(mfo), 33'h1);
        chk(33'(sep), 33'h1);
        chk(33'(poe), 33'h1);
        wr(12'h094, 32'h1);
        idle(2);
        chk(33'(poe), 33'h0);
        wr(12'h004, 32'h3);
        wr(12'h000, 32'h00);
        wr(12'h084, 32'hff);
        idle(2);
        chk(33'(plus_s), 33'h0);
        chk(33'(mfo), 33'h0);
        chk(33'(conn), 33'hfe);
        wr(12'h000, 32'h10);
        idle(4);
        rd(12'h084, 32'h1);
        results();
    end
endmodule // tb_comparator_output_logic
